//--- bench/fcma_conv_model.sv
`timescale 1ns/1ps
module fcma_conv_model (
    // clock
    input wire logic            i_clk,
    // request
    input wire logic            i_start,
    input wire logic [2:0]      i_chan,
    input wire logic            i_slow,
    input wire logic [4:0][11:0] i_vals,
    // answer
    output logic                o_done,
    output logic [11:0]         o_data
);
    initial begin
        o_done = 1'b0;
        o_data = 12'h000;
    end

    // answer each start, data inverted outside the done cycle
    always begin
        @(posedge i_clk);
        if (i_start) begin
            repeat (i_slow ? 6 : 1) @(posedge i_clk);
            o_done <= 1'b1;
            o_data <= i_vals[i_chan];
            @(posedge i_clk);
            o_done <= 1'b0;
            o_data <= ~o_data;
        end
    end
endmodule

//--- bench/fcma_top_sva.sv
`timescale 1ns/1ps
module fcma_top_chk
    import fcma_pkg::*;
#(
    parameter int P_FRAME_CYC = 200
) (
    // clock and reset
    input wire logic        i_clk,
    input wire logic        i_sys_rst,
    // bus
    input wire logic        i_hsel,
    input wire logic [1:0]  i_htrans,
    input wire logic        i_hwrite,
    input wire logic        i_hready,
    input wire logic [31:0] o_hrdata,
    // converter
    input wire logic        o_conv_start,
    input wire logic [2:0]  o_conv_chan,
    input wire logic        i_conv_done,
    // pins
    input wire logic        i_buffer_input_a,
    input wire logic        i_buffer_input_b,
    input wire logic        o_open_drain_output_a,
    input wire logic        o_open_drain_output_a_oe_n,
    input wire logic        o_open_drain_output_b,
    input wire logic        o_open_drain_output_b_oe_n,
    input wire logic        o_irq
);
    logic [2:0] last_r;
    logic [2:0] age_r;

    // last started channel and cycles since reset, saturating at 4
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            last_r <= 3'h0;
            age_r  <= 3'h0;
        end else begin
            if (o_conv_start) last_r <= o_conv_chan;
            if (age_r != 3'h4) age_r <= age_r + 3'h1;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    property p_pulse; o_conv_start |=> !o_conv_start; endproperty
    property p_chan; o_conv_start |-> o_conv_chan <= CH_LAST; endproperty
    property p_rot;
        o_conv_start && o_conv_chan != 3'h0 |-> o_conv_chan == last_r + 3'h1;
    endproperty
    property p_next; i_conv_done && o_conv_chan != CH_LAST |-> ##2 o_conv_start; endproperty
    property p_hold;
        !(i_hsel && i_htrans[1] && !i_hwrite && i_hready) |=> $stable(o_hrdata);
    endproperty
    property p_bufb;
        age_r == 3'h4 |-> o_open_drain_output_b_oe_n == $past(i_buffer_input_b, 3);
    endproperty
    property p_bufa;
        age_r == 3'h4 && $past(i_buffer_input_a, 3) |-> o_open_drain_output_a_oe_n;
    endproperty
    property p_odlow; !o_open_drain_output_a && !o_open_drain_output_b; endproperty

    a_pulse: assert property (p_pulse) else $error("start pulse too long");
    a_chan: assert property (p_chan) else $error("channel out of range");
    a_rot: assert property (p_rot) else $error("rotation order broken");
    a_next: assert property (p_next) else $error("next start late");
    a_hold: assert property (p_hold) else $error("read data moved");
    a_bufb: assert property (p_bufb) else $error("buffer b wrong");
    a_bufa: assert property (p_bufa) else $error("buffer a wrong");
    a_odlow: assert property (p_odlow) else $error("drive level not low");

    c_done: cover property (i_conv_done && o_conv_chan == CH_LAST);
    c_irq: cover property ($rose(o_irq));
    c_rd: cover property (i_hsel && i_htrans[1] && !i_hwrite);
endmodule

//--- bench/five_channel_monitor_alarm_bench.sv
`timescale 1ns/1ps
module five_channel_monitor_alarm_bench;
    import fcma_pkg::*;
    localparam int F = 200;
    logic i_clk, i_sys_rst, hsel, hwrite, rdy, hresp, cstart, cdone, slow;
    logic wp, in_a, in_b, od_a, od_b, oen_a, oen_b, irq;
    logic [1:0]       htrans;
    logic [31:0]      haddr, hwdata, hrdata, v;
    logic [2:0]       cchan;
    logic [11:0]      cdata, cv;
    logic [4:0][11:0] vals;
    logic [15:0]      hi [5];
    logic [15:0]      lo [5];
    int err_total = 0, checks = 0, seed = 33, cyc_cnt = 0, n, c;

    // pulled-up open-drain pins
    assign od_a = oen_a;
    assign od_b = oen_b;

    fcma_top #(.P_FRAME_CYC(F)) i_dut (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(rdy), .o_hrdata(hrdata), .o_hreadyout(rdy), .o_hresp(hresp),
        .o_conv_start(cstart), .o_conv_chan(cchan), .i_conv_done(cdone),
        .i_conv_data(cdata), .i_write_protect_pin(wp), .i_buffer_input_a(in_a),
        .i_buffer_input_b(in_b), .i_open_drain_output_a(od_a),
        .i_open_drain_output_b(od_b), .o_open_drain_output_a(),
        .o_open_drain_output_a_oe_n(oen_a), .o_open_drain_output_b(),
        .o_open_drain_output_b_oe_n(oen_b), .o_irq(irq));

    fcma_conv_model i_conv (.i_clk(i_clk), .i_start(cstart), .i_chan(cchan),
        .i_slow(slow), .i_vals(vals), .o_done(cdone), .o_data(cdata));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic close_out();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge i_clk);
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge i_clk); while (rdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge i_clk); while (rdy !== 1'b1);
        v = hrdata;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(v, e);
    endtask

    // expected status after a full frame
    function automatic logic [14:0] exp_st();
        logic [15:0] r;
        logic [14:0] s;
        s = 15'h1f;
        for (int k = 0; k < 5; k++) begin
            r = {vals[k], 4'h0};
            s[5+k] = (k == 4) ? $signed(r) > $signed(hi[k]) : r > hi[k];
            s[10+k] = (k == 4) ? $signed(r) < $signed(lo[k]) : r < lo[k];
        end
        return s;
    endfunction

    always @(posedge i_clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 30000) begin
            err_total++;
            close_out();
        end
    end

    initial begin
        i_sys_rst = 1'b1;
        {hsel, hwrite, wp, in_a, in_b, slow} = 6'h0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        vals = '0;
        cyc(6);
        i_sys_rst <= 1'b0;
        cyc(1);
        rd(ADDR_CTRL, 32'h4);
        rd(ADDR_MASK, 32'h0);
        rd(ADDR_LIMIT0 + 8'h20, 32'h7fff);
        rd(ADDR_LIMIT0 + 8'h24, 32'h8000);
        rd(ADDR_LIMIT0, 32'hffff);
        rd(8'h30, 32'h0);
        for (n = 0; n < 6; n++) begin
            for (c = 0; c < 5; c++) begin
                cv = 12'($random(seed));
                hi[c] = 16'($random(seed));
                lo[c] = 16'($random(seed));
                // boundary values and most negative temperature
                if (n == 0) begin
                    hi[c] = 16'hfff0;
                    lo[c] = 16'h0000;
                    cv = (c == 4) ? 12'h800 : 12'hfff;
                end
                vals[c] <= cv;
                bus(1'b1, ADDR_LIMIT0 + 8'(8 * c), {16'h0, hi[c]});
                bus(1'b1, ADDR_LIMIT0 + 8'(8 * c + 4), {16'h0, lo[c]});
            end
            {in_a, in_b} <= 2'($random(seed));
            slow <= n[1];
            cyc(F);
            bus(1'b1, ADDR_STATUS, 32'h7fff);
            cyc(2 * F);
            for (c = 0; c < 5; c++)
                rd(ADDR_RESULT0 + 8'(4 * c), {16'h0, vals[c], 4'h0});
            // reader drops the four padding bits of the last word
            chk({20'h0, v[15:4]}, {20'h0, vals[4]});
            rd(ADDR_STATUS, {17'h0, exp_st()});
        end
        vals[1] <= 12'h123;
        bus(1'b1, ADDR_LIMIT0 + 8'h8, 32'h0);
        cyc(2 * F);
        bus(1'b1, ADDR_MASK, 32'h40);
        cyc(3);
        #1 chk({31'h0, irq}, 32'h1);
        cyc(1);
        bus(1'b1, ADDR_MASK, 32'h0);
        cyc(3);
        #1 chk({31'h0, irq}, 32'h0);
        cyc(1);
        in_a <= 1'b0;
        bus(1'b1, ADDR_CTRL, 32'h5);
        cyc(4);
        #1 chk({31'h0, oen_a}, 32'h1);
        cyc(1);
        bus(1'b1, ADDR_CTRL, 32'h0);
        cyc(2 * F);
        bus(1'b1, ADDR_STATUS, 32'h7fff);
        rd(ADDR_STATUS, 32'h0);
        #1 chk({31'h0, oen_a}, 32'h0);
        cyc(1);
        bus(1'b1, ADDR_MASK, 32'h40);
        cyc(3);
        #1 chk({31'h0, irq}, 32'h0);
        cyc(1);
        wp <= 1'b1;
        bus(1'b1, ADDR_CTRL, 32'h2);
        cyc(3);
        bus(1'b1, ADDR_MASK, 32'h1f);
        rd(ADDR_MASK, 32'h40);
        bus(1'b0, ADDR_PINS, 32'h0);
        // out pins read back through the pull-ups: a held low, b follows in_b
        chk({26'h0, v[5:0]}, {26'h0, in_b, 1'b0, in_b, 3'h3});
        wp <= 1'b0;
        cyc(4);
        bus(1'b1, ADDR_MASK, 32'h1f);
        rd(ADDR_MASK, 32'h1f);
        bus(1'b1, ADDR_RESULT0, 32'hffff);
        rd(ADDR_RESULT0, {16'h0, vals[0], 4'h0});
        chk({30'h0, rdy, hresp}, 32'h2);
        close_out();
    end
endmodule

bind fcma_top fcma_top_chk #(.P_FRAME_CYC(P_FRAME_CYC)) i_chk (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_hsel(i_hsel), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hrdata(o_hrdata),
    .o_conv_start(o_conv_start), .o_conv_chan(o_conv_chan), .i_conv_done(i_conv_done),
    .i_buffer_input_a(i_buffer_input_a), .i_buffer_input_b(i_buffer_input_b),
    .o_open_drain_output_a(o_open_drain_output_a),
    .o_open_drain_output_a_oe_n(o_open_drain_output_a_oe_n),
    .o_open_drain_output_b(o_open_drain_output_b),
    .o_open_drain_output_b_oe_n(o_open_drain_output_b_oe_n), .o_irq(o_irq));

//--- logic/fcma_cmp.sv
`timescale 1ns/1ps
module fcma_cmp (
    // operands
    input  wire logic [15:0] i_value,
    input  wire logic [15:0] i_hi,
    input  wire logic [15:0] i_lo,
    input  wire logic        i_signed,
    // result
    output logic             o_above,
    output logic             o_below
);

    always_comb begin
        if (i_signed) begin
            o_above = $signed(i_value) > $signed(i_hi);
            o_below = $signed(i_value) < $signed(i_lo);
        end else begin
            o_above = i_value > i_hi;
            o_below = i_value < i_lo;
        end
    end

endmodule

//--- logic/fcma_pkg.sv
package fcma_pkg;

    // clock and frame timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int FRAME_TYP_MS  = 25;
    localparam int FRAME_MAX_MS  = 36;
    localparam int FRAME_CYC     = FRAME_TYP_MS * 1000000 / CLK_PERIOD_NS;
    localparam int FRAME_MAX_CYC = FRAME_MAX_MS * 1000000 / CLK_PERIOD_NS;
    localparam int FRAME_W       = 22;

    // channels and word layout
    localparam int NCH    = 5;
    localparam int RES_W  = 16;
    localparam int ACC_W  = 12;
    localparam int PAD_W  = RES_W - ACC_W;
    localparam logic [2:0] CH_VCC   = 3'h0;
    localparam logic [2:0] CH_MON_A = 3'h1;
    localparam logic [2:0] CH_MON_B = 3'h2;
    localparam logic [2:0] CH_MON_C = 3'h3;
    localparam logic [2:0] CH_TEMP  = 3'h4;
    localparam logic [2:0] CH_LAST  = CH_TEMP;

    // register byte offsets
    localparam logic [7:0] ADDR_RESULT0 = 8'h00;
    localparam logic [7:0] ADDR_STATUS  = 8'h14;
    localparam logic [7:0] ADDR_MASK    = 8'h18;
    localparam logic [7:0] ADDR_CTRL    = 8'h1c;
    localparam logic [7:0] ADDR_PINS    = 8'h20;
    localparam logic [7:0] ADDR_LIMIT0  = 8'h40;
    localparam logic [7:0] ADDR_NONE    = 8'hff;

    // status and mask layout
    localparam int ST_DONE_LSB = 0;
    localparam int ST_HI_LSB   = 5;
    localparam int ST_LO_LSB   = 10;
    localparam int ST_W        = 15;

    // control bits
    localparam int CTRL_ALARM_OUT    = 0;
    localparam int CTRL_MAIN_PROTECT = 1;
    localparam int CTRL_RUN          = 2;
    localparam int CTRL_W            = 3;
    localparam logic [CTRL_W-1:0] CTRL_RST = 3'h4;

    // limit reset values
    localparam logic [RES_W-1:0] LIM_HI_RST_U = 16'hffff;
    localparam logic [RES_W-1:0] LIM_LO_RST_U = 16'h0000;
    localparam logic [RES_W-1:0] LIM_HI_RST_S = 16'h7fff;
    localparam logic [RES_W-1:0] LIM_LO_RST_S = 16'h8000;

    // pin synchroniser layout and reset
    localparam int PIN_WP   = 0;
    localparam int PIN_IN_A = 1;
    localparam int PIN_IN_B = 2;
    localparam int PIN_OD_A = 3;
    localparam int PIN_OD_B = 4;
    localparam int PIN_W    = 5;
    localparam logic [PIN_W-1:0] PIN_RST = 5'h19;

    typedef enum logic [1:0] {
        SEQ_IDLE  = 2'b00,
        SEQ_START = 2'b01,
        SEQ_WAIT  = 2'b10
    } fcma_seq_type;

    typedef struct packed {
        logic [NCH-1:0][RES_W-1:0] res;
        logic [NCH-1:0][RES_W-1:0] lim_hi;
        logic [NCH-1:0][RES_W-1:0] lim_lo;
        logic [ST_W-1:0]           status;
        logic [ST_W-1:0]           mask;
        logic [CTRL_W-1:0]         ctrl;
        fcma_seq_type              seq;
        logic [2:0]                chan;
        logic [FRAME_W-1:0]        frame_cnt;
        logic                      conv_start;
        logic [NCH-1:0]            fresh;
        logic                      dph_wr;
        logic [7:0]                dph_addr;
        logic [31:0]               hrdata;
        logic                      irq;
        logic                      od_a_rel;
        logic                      od_b_rel;
    } fcma_state_type;

    localparam fcma_state_type STATE_RST = '{
        res:        '0,
        lim_hi:     {LIM_HI_RST_S, {4{LIM_HI_RST_U}}},
        lim_lo:     {LIM_LO_RST_S, {4{LIM_LO_RST_U}}},
        status:     '0,
        mask:       '0,
        ctrl:       CTRL_RST,
        seq:        SEQ_IDLE,
        chan:       3'h0,
        frame_cnt:  '0,
        conv_start: 1'b0,
        fresh:      '0,
        dph_wr:     1'b0,
        dph_addr:   ADDR_NONE,
        hrdata:     32'h0000_0000,
        irq:        1'b0,
        od_a_rel:   1'b1,
        od_b_rel:   1'b1
    };

endpackage

//--- logic/fcma_sync.sv
`timescale 1ns/1ps
module fcma_sync #(
    parameter int                W         = 1,
    parameter logic [W-1:0]      P_RST_VAL = '0
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_sys_rst,
    // levels
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta_r <= P_RST_VAL;
            sync_r <= P_RST_VAL;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;

endmodule

//--- logic/fcma_top.sv
// Contract
// (R1) each channel read as 16-bit word, 12-bit result left-justified
// (R2) reader masks the four low bits before computing a value
// (R3) channels refreshed one after another in fixed rotating order each frame
// (R4) a finished conversion sets that channel's done bit
// (R5) results compared to high and low limits, alarm flag set on excursion
// (R6) interrupt enable per channel for its limit alarms
// (R7) first open-drain output can assert while any channel is out of limit
// (R8) two buffers: input a to output a, input b to output b
// (R9) protect pin low means no protection; pin has an internal pull-up
// (R10) temperature is two's complement, 7fff top, 8000 bottom
// (R11) supply word unsigned, 100 uV per count
// (R12) analog inputs unsigned, 38.147 uV per count, ffff is full scale
// (R13) one full rotation per frame of 25 ms typical, 36 ms at most
// (R14) temperature upper byte whole degrees, lower byte 1/256 degree
// (R15) writes blocked only while protect pin high and main protect bit set; code never blocks writes to the status clear register
// (R16) each 16-bit result captured whole, never mixed across conversions
`timescale 1ns/1ps
module fcma_top
    import fcma_pkg::*;
#(
    parameter int P_FRAME_CYC = fcma_pkg::FRAME_CYC
) (
    // clock and reset
    input  wire logic                     i_clk,
    input  wire logic                     i_sys_rst,
    // ahb-lite slave
    input  wire logic                     i_hsel,
    input  wire logic [31:0]              i_haddr,
    input  wire logic [1:0]               i_htrans,
    input  wire logic                     i_hwrite,
    input  wire logic [2:0]               i_hsize,
    input  wire logic [31:0]              i_hwdata,
    input  wire logic                     i_hready,
    output logic      [31:0]              o_hrdata,
    output logic                          o_hreadyout,
    output logic                          o_hresp,
    // converter handshake
    output logic                          o_conv_start,
    output logic      [2:0]               o_conv_chan,
    input  wire logic                     i_conv_done,
    input  wire logic [fcma_pkg::ACC_W-1:0] i_conv_data,
    // pins
    input  wire logic                     i_write_protect_pin,
    input  wire logic                     i_buffer_input_a,
    input  wire logic                     i_buffer_input_b,
    input  wire logic                     i_open_drain_output_a,
    input  wire logic                     i_open_drain_output_b,
    output logic                          o_open_drain_output_a,
    output logic                          o_open_drain_output_a_oe_n,
    output logic                          o_open_drain_output_b,
    output logic                          o_open_drain_output_b_oe_n,
    // interrupt
    output logic                          o_irq
);
    import fcma_pkg::*;

    fcma_state_type    st_r;
    fcma_state_type    st_nxt;
    logic [PIN_W-1:0]  pins_sync;
    logic [NCH-1:0]    above;
    logic [NCH-1:0]    below;
    logic              protect;
    logic              take;
    logic              hit;
    logic [31:0]       rd_mux;
    logic [ST_W-1:0]   set_bits;
    logic [2:0]        lim_idx;
    logic [2:0]        res_idx;

    fcma_sync #(
        .W         (PIN_W),
        .P_RST_VAL (PIN_RST)
    ) u_sync (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   ({i_open_drain_output_b, i_open_drain_output_a,
                     i_buffer_input_b, i_buffer_input_a, i_write_protect_pin}),
        .o_sync    (pins_sync)
    );

    // one comparator per channel, temperature signed
    for (genvar g = 0; g < NCH; g++) begin : g_cmp
        fcma_cmp u_cmp (
            .i_value  (st_r.res[g]),
            .i_hi     (st_r.lim_hi[g]),
            .i_lo     (st_r.lim_lo[g]),
            .i_signed (1'(g == int'(CH_TEMP))), // R10
            .o_above  (above[g]),
            .o_below  (below[g])
        );
    end

    assign protect = pins_sync[PIN_WP] & st_r.ctrl[CTRL_MAIN_PROTECT]; // R9 R15
    assign take    = i_hsel & i_htrans[1] & i_hready;
    assign hit     = (i_haddr[31:8] == 24'h00_0000) & (i_haddr[1:0] == 2'b00);
    assign res_idx = i_haddr[4:2];
    assign lim_idx = st_r.dph_addr[5:3];

    // read mux, sampled at the address phase
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (!hit) begin
            rd_mux = 32'h0000_0000;
        end else if (i_haddr[7:5] == 3'h0 && res_idx < 3'(NCH)) begin
            rd_mux[RES_W-1:0] = st_r.res[res_idx]; // R1 R16
        end else if (i_haddr[7:0] == ADDR_STATUS) begin
            rd_mux[ST_W-1:0] = st_r.status;
        end else if (i_haddr[7:0] == ADDR_MASK) begin
            rd_mux[ST_W-1:0] = st_r.mask;
        end else if (i_haddr[7:0] == ADDR_CTRL) begin
            rd_mux[CTRL_W-1:0] = st_r.ctrl;
        end else if (i_haddr[7:0] == ADDR_PINS) begin
            rd_mux[PIN_W:0] = {pins_sync, protect};
        end else if (i_haddr[7:6] == ADDR_LIMIT0[7:6] && i_haddr[5:3] < 3'(NCH)) begin
            if (i_haddr[2]) begin
                rd_mux[RES_W-1:0] = st_r.lim_lo[i_haddr[5:3]];
            end else begin
                rd_mux[RES_W-1:0] = st_r.lim_hi[i_haddr[5:3]];
            end
        end
    end

    // sticky events: done per channel, then high and low alarms
    assign set_bits = {st_r.fresh & below, st_r.fresh & above, st_r.fresh}; // R4 R5

    always_comb begin
        st_nxt            = st_r;
        st_nxt.conv_start = 1'b0;
        st_nxt.fresh      = '0;

        // free-running frame timer
        if (st_r.frame_cnt == '0) begin
            st_nxt.frame_cnt = FRAME_W'(P_FRAME_CYC - 1); // R13
        end else begin
            st_nxt.frame_cnt = st_r.frame_cnt - 1'b1;
        end

        // round-robin conversion sequencer
        case (st_r.seq)
            SEQ_IDLE: begin
                if (st_r.frame_cnt == '0 && st_r.ctrl[CTRL_RUN]) begin // R3 R13
                    st_nxt.chan = CH_VCC;
                    st_nxt.seq  = SEQ_START;
                end
            end
            SEQ_START: begin
                st_nxt.conv_start = 1'b1;
                st_nxt.seq        = SEQ_WAIT;
            end
            SEQ_WAIT: begin
                if (i_conv_done) begin
                    // whole word stored in one edge, low bits zero
                    st_nxt.res[st_r.chan]   = {i_conv_data, PAD_W'(0)}; // R1 R11 R12 R14 R16
                    st_nxt.fresh[st_r.chan] = 1'b1;
                    if (st_r.chan == CH_LAST) begin
                        st_nxt.seq = SEQ_IDLE;
                    end else begin
                        st_nxt.chan = st_r.chan + 3'h1; // R3
                        st_nxt.seq  = SEQ_START;
                    end
                end
            end
            default: begin
                st_nxt.seq = SEQ_IDLE;
            end
        endcase

        // write data phase
        if (st_r.dph_wr) begin
            if (st_r.dph_addr == ADDR_STATUS) begin
                st_nxt.status = st_r.status & ~i_hwdata[ST_W-1:0];
            end else if (protect) begin
                st_nxt.status = st_r.status; // R15
            end else if (st_r.dph_addr == ADDR_MASK) begin
                st_nxt.mask = i_hwdata[ST_W-1:0]; // R6
            end else if (st_r.dph_addr == ADDR_CTRL) begin
                st_nxt.ctrl = i_hwdata[CTRL_W-1:0];
            end else if (st_r.dph_addr[7:6] == ADDR_LIMIT0[7:6] && lim_idx < 3'(NCH)) begin
                if (st_r.dph_addr[2]) begin
                    st_nxt.lim_lo[lim_idx] = i_hwdata[RES_W-1:0];
                end else begin
                    st_nxt.lim_hi[lim_idx] = i_hwdata[RES_W-1:0];
                end
            end
        end
        // set wins over a clear in the same cycle
        st_nxt.status = st_nxt.status | set_bits; // R4 R5

        // address phase
        st_nxt.dph_wr   = take & i_hwrite;
        st_nxt.dph_addr = hit ? i_haddr[7:0] : ADDR_NONE;
        if (take && !i_hwrite) begin
            st_nxt.hrdata = rd_mux;
        end

        // interrupt and pins
        st_nxt.irq      = |(st_r.status & st_r.mask); // R6
        st_nxt.od_a_rel = pins_sync[PIN_IN_A]
                        | (st_r.ctrl[CTRL_ALARM_OUT]
                           & |st_r.status[ST_W-1:ST_HI_LSB]); // R7 R8
        st_nxt.od_b_rel = pins_sync[PIN_IN_B]; // R8
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_r <= STATE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // zero-wait slave, always okay
    assign o_hrdata     = st_r.hrdata;
    assign o_hreadyout  = 1'b1;
    assign o_hresp      = 1'b0;
    assign o_conv_start = st_r.conv_start;
    assign o_conv_chan  = st_r.chan;
    assign o_irq        = st_r.irq;

    // open drain: pin pulled low when enable is low
    assign o_open_drain_output_a      = 1'b0;
    assign o_open_drain_output_a_oe_n = st_r.od_a_rel;
    assign o_open_drain_output_b      = 1'b0;
    assign o_open_drain_output_b_oe_n = st_r.od_b_rel;

endmodule
